// ### status_service_request_tree.v
// Notes on behaviour
// - ESR bits 5,4,3,2: command/exec/device/query errors
// - Std summary when enabled ESR bit set
// - SRE bit7 operation, bit5 standard; raise request
// - Condition bits: connected,access,paging,-,register,active
// - Call summary needs event and enable bit
// - Call summary feeds operation condition bit 9
// - Buffer commands, execute serially in order
// - Completion query answers after prior commands finish
// - Reset command takes seconds; clear-status clears
// - Transition filter passes only selected rises
// - Event bit set on filtered rising condition
// - Reading call event register clears it
`timescale 1ns/1ps
`include "status_tree_map.vh"

module status_service_request_tree #(
  parameter [31:0] RESET_CYCLES = `RESET_CYCLES
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_cmd_valid,
  input wire [3:0] i_cmd_code,
  input wire [15:0] i_cmd_data,
  output wire o_cmd_ready,
  output wire o_rsp_valid,
  output wire [15:0] o_rsp_data,
  input wire i_rsp_ready,
  input wire [5:0] i_indicators,
  input wire i_exec_err,
  input wire i_dev_err,
  input wire i_query_err,
  output wire o_srq,
  output wire o_busy
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_EXEC = 4'b0010;
  localparam [3:0] S_RESET = 4'b0100;
  localparam [3:0] S_REPLY = 4'b1000;

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [`CMD_WIDTH-1:0] cmd_reg;
  reg [31:0] rst_cnt_reg;
  reg [7:0] ese_reg;
  reg [7:0] sre_reg;
  reg [15:0] cp_enab_reg;
  reg [15:0] oper_enab_reg;
  reg [15:0] cp_ptr_reg;
  reg [15:0] cp_cond_reg;
  reg [15:0] cp_prev_reg;
  reg [15:0] cp_event_reg;
  reg [7:0] esr_reg;
  reg [15:0] rsp_data_reg;
  reg rsp_valid_reg;

  wire buf_valid;
  wire [`CMD_WIDTH-1:0] buf_data;
  wire buf_pop;
  wire [3:0] code;
  wire [15:0] data;
  wire std_summary;
  wire cp_summary;
  reg [15:0] oper_cond;
  wire oper_summary;
  reg [7:0] stb_base;
  wire rqs;
  reg [7:0] stb;
  wire [15:0] cp_rise;
  wire do_cls;
  wire do_rst;
  wire rd_esr;
  wire rd_cp_event;
  wire cmd_unknown;
  reg [7:0] esr_set;

  // Commands are queued so the controller can send bursts
  cmd_buffer u_cmd_buffer (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr_valid(i_cmd_valid),
    .i_wr_data({i_cmd_code, i_cmd_data}),
    .o_wr_ready(o_cmd_ready),
    .o_rd_valid(buf_valid),
    .o_rd_data(buf_data),
    .i_rd_ready(buf_pop)
  );

  // Pop only while idle, so one command runs at a time
  assign buf_pop = (state_reg == S_IDLE) & buf_valid;

  assign code = cmd_reg[`CMD_WIDTH-1:16];
  assign data = cmd_reg[15:0];
  assign do_rst = (state_reg == S_EXEC) & (code == `CMD_RST);
  assign do_cls = (state_reg == S_EXEC) & (code == `CMD_CLS);
  assign rd_esr = (state_reg == S_EXEC) & (code == `CMD_READ_ESR);
  assign rd_cp_event = (state_reg == S_EXEC) &
                       (code == `CMD_READ_CP_EVENT);
  assign cmd_unknown = (state_reg == S_EXEC) & (code > `CMD_READ_CP_COND);

  function is_query;
    input [3:0] c;
    begin
      is_query = (c == `CMD_READ_ESR) || (c == `CMD_READ_CP_EVENT) ||
                 (c == `CMD_READ_STB) || (c == `CMD_OPC_QUERY) ||
                 (c == `CMD_READ_CP_COND);
    end
  endfunction

  // One group's summary: any event bit whose enable bit is also set
  function any_enabled;
    input [15:0] ev;
    input [15:0] en;
    begin
      any_enabled = |(ev & en);
    end
  endfunction

  // Summary chain toward the status byte
  assign cp_summary = any_enabled(cp_event_reg, cp_enab_reg);
  assign oper_summary = any_enabled(oper_cond, oper_enab_reg);
  assign std_summary = any_enabled({8'h00, esr_reg},
                                   {8'h00, ese_reg});
  // Bit 6 of the enable mask is ignored, so the request cannot feed itself
  assign rqs = |(stb_base & sre_reg & 8'hA0);
  assign o_srq = rqs;

  // Only the call summary drives the operation condition here, so the
  // operation group needs no event latch of its own
  always @* begin
    oper_cond = 16'h0000;
    oper_cond[`OPER_CP_SUMMARY] = cp_summary;
  end

  always @* begin
    stb_base = 8'h00;
    stb_base[`STB_OPER_SUMMARY] = oper_summary;
    stb_base[`STB_STD_SUMMARY] = std_summary;
  end

  always @* begin
    stb = stb_base;
    stb[`STB_RQS] = rqs;
  end

  // Filtered rising edges of the indicator conditions
  assign cp_rise = cp_cond_reg & ~cp_prev_reg & cp_ptr_reg;

  always @* begin
    esr_set = 8'h00;
    esr_set[`ESR_CMD_ERR] = cmd_unknown;
    esr_set[`ESR_EXEC_ERR] = i_exec_err;
    esr_set[`ESR_DEV_ERR] = i_dev_err;
    esr_set[`ESR_QUERY_ERR] = i_query_err;
  end

  always @* begin
    case (state_reg)
      S_IDLE: begin
        if (buf_valid) begin
          state_next = S_EXEC;
        end else begin
          state_next = S_IDLE;
        end
      end
      S_EXEC: begin
        if (code == `CMD_RST) begin
          state_next = S_RESET;
        end else if (is_query(code)) begin
          state_next = S_REPLY;
        end else begin
          state_next = S_IDLE;
        end
      end
      S_RESET: begin
        if (rst_cnt_reg == 32'h0000_0000) begin
          state_next = S_IDLE;
        end else begin
          state_next = S_RESET;
        end
      end
      S_REPLY: begin
        if (i_rsp_ready) begin
          state_next = S_IDLE;
        end else begin
          state_next = S_REPLY;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= S_IDLE;
      cmd_reg <= {`CMD_WIDTH{1'b0}};
      rst_cnt_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      if (buf_pop) begin
        cmd_reg <= buf_data;
      end
      if (do_rst) begin
        rst_cnt_reg <= RESET_CYCLES - 32'h0000_0001;
      end else if (state_reg == S_RESET) begin
        rst_cnt_reg <= rst_cnt_reg - 32'h0000_0001;
      end
    end
  end

  // Enable masks and filters; the reset command presets all of them
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ese_reg <= `ESE_RESET;
      sre_reg <= `SRE_RESET;
      cp_enab_reg <= `CP_ENAB_RESET;
      oper_enab_reg <= `OPER_ENAB_RESET;
      cp_ptr_reg <= `CP_PTR_RESET;
    end else if (do_rst) begin
      ese_reg <= `ESE_RESET;
      sre_reg <= `SRE_RESET;
      cp_enab_reg <= `CP_ENAB_RESET;
      oper_enab_reg <= `OPER_ENAB_RESET;
      cp_ptr_reg <= `CP_PTR_RESET;
    end else if (state_reg == S_EXEC) begin
      case (code)
        `CMD_SET_ESE: begin
          ese_reg <= data[7:0];
        end
        `CMD_SET_SRE: begin
          sre_reg <= data[7:0];
        end
        `CMD_SET_CP_ENAB: begin
          cp_enab_reg <= data & `CP_USED_MASK;
        end
        `CMD_SET_OPER_ENAB: begin
          oper_enab_reg <= data;
        end
        `CMD_SET_CP_PTR: begin
          cp_ptr_reg <= data & `CP_USED_MASK;
        end
        default: begin
          ese_reg <= ese_reg;
        end
      endcase
    end
  end

  // Condition tracking and sticky events; a new set beats a clear
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cp_cond_reg <= 16'h0000;
      cp_prev_reg <= 16'h0000;
      cp_event_reg <= 16'h0000;
      esr_reg <= 8'h00;
    end else begin
      cp_cond_reg <= {10'h000, i_indicators} & `CP_USED_MASK;
      cp_prev_reg <= cp_cond_reg;
      if (do_cls || do_rst || rd_cp_event) begin
        cp_event_reg <= cp_rise;
      end else begin
        cp_event_reg <= cp_event_reg | cp_rise;
      end
      if (do_cls || do_rst || rd_esr) begin
        esr_reg <= esr_set;
      end else begin
        esr_reg <= esr_reg | esr_set;
      end
    end
  end

  // Reply register; completion query answers only once it is reached
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 16'h0000;
    end else if (state_reg == S_EXEC && is_query(code)) begin
      rsp_valid_reg <= 1'b1;
      case (code)
        `CMD_READ_ESR: begin
          rsp_data_reg <= {8'h00, esr_reg};
        end
        `CMD_READ_CP_EVENT: begin
          rsp_data_reg <= cp_event_reg;
        end
        `CMD_READ_STB: begin
          rsp_data_reg <= {8'h00, stb};
        end
        `CMD_READ_CP_COND: begin
          rsp_data_reg <= cp_cond_reg;
        end
        default: begin
          rsp_data_reg <= 16'h0001;
        end
      endcase
    end else if (state_reg == S_REPLY && i_rsp_ready) begin
      rsp_valid_reg <= 1'b0;
    end
  end

  assign o_rsp_valid = rsp_valid_reg;
  assign o_rsp_data = rsp_data_reg;
  assign o_busy = (state_reg != S_IDLE) | buf_valid;
endmodule

// ### status_tree_map.vh
`ifndef STATUS_TREE_MAP_VH
`define STATUS_TREE_MAP_VH

// Command codes presented on the command port
`define CMD_RST 4'h0
`define CMD_CLS 4'h1
`define CMD_SET_ESE 4'h2
`define CMD_SET_SRE 4'h3
`define CMD_SET_CP_ENAB 4'h4
`define CMD_SET_OPER_ENAB 4'h5
`define CMD_SET_CP_PTR 4'h6
`define CMD_READ_ESR 4'h7
`define CMD_READ_CP_EVENT 4'h8
`define CMD_READ_STB 4'h9
`define CMD_OPC_QUERY 4'hA
`define CMD_READ_CP_COND 4'hB

// Standard event register bits
`define ESR_QUERY_ERR 2
`define ESR_DEV_ERR 3
`define ESR_EXEC_ERR 4
`define ESR_CMD_ERR 5

// Status byte bits
`define STB_STD_SUMMARY 5
`define STB_RQS 6
`define STB_OPER_SUMMARY 7

// Call-processing condition bits
`define CP_ACTIVE 0
`define CP_REGISTER 1
`define CP_UNUSED 2
`define CP_PAGING 3
`define CP_ACCESS 4
`define CP_CONNECTED 5
`define CP_USED_MASK 16'h003B

// Operation condition bit fed by the call-processing summary
`define OPER_CP_SUMMARY 9

// Reset values
`define ESE_RESET 8'h00
`define SRE_RESET 8'h00
`define CP_ENAB_RESET 16'h0000
`define OPER_ENAB_RESET 16'h0000
`define CP_PTR_RESET 16'h0000

// Command buffer geometry
`define CMD_WIDTH 20
`define CMD_DEPTH 16
`define CMD_AW 4

// Instrument reset duration
`define CLK_MHZ 50
`define RESET_TIME_MS 2000
`define RESET_CYCLES (`RESET_TIME_MS * `CLK_MHZ * 1000)

`endif

// ### cmd_buffer.v
`timescale 1ns/1ps
`include "status_tree_map.vh"

module cmd_buffer (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_wr_valid,
  input wire [`CMD_WIDTH-1:0] i_wr_data,
  output wire o_wr_ready,
  output wire o_rd_valid,
  output wire [`CMD_WIDTH-1:0] o_rd_data,
  input wire i_rd_ready
);
  reg [`CMD_WIDTH-1:0] mem [0:`CMD_DEPTH-1];
  reg [`CMD_AW:0] wr_ptr_reg;
  reg [`CMD_AW:0] rd_ptr_reg;
  wire full;
  wire empty;
  wire do_wr;
  wire do_rd;

  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[`CMD_AW] != rd_ptr_reg[`CMD_AW]) &&
                (wr_ptr_reg[`CMD_AW-1:0] == rd_ptr_reg[`CMD_AW-1:0]);
  assign o_wr_ready = ~full;
  assign o_rd_valid = ~empty;
  assign o_rd_data = mem[rd_ptr_reg[`CMD_AW-1:0]];
  assign do_wr = i_wr_valid & ~full;
  assign do_rd = i_rd_ready & ~empty;

  // Memory has no reset so it can map onto plain RAM
  always @(posedge i_sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg[`CMD_AW-1:0]] <= i_wr_data;
    end
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= {(`CMD_AW+1){1'b0}};
      rd_ptr_reg <= {(`CMD_AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// ### sreq_tree_checker_assertions.sv
`timescale 1ns/1ps
`include "status_tree_map.vh"
module sreq_tree_checker (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_cmd_valid,
  input wire [3:0] i_cmd_code,
  input wire o_cmd_ready,
  input wire o_rsp_valid,
  input wire [15:0] o_rsp_data,
  input wire i_rsp_ready,
  input wire o_srq,
  input wire o_busy
);
  wire take = i_cmd_valid & o_cmd_ready;
  default clocking cb @(posedge i_sys_clk); endclocking
  a_reset_quiet: assert property (@(posedge i_sys_clk) !i_rst_n |->
    o_cmd_ready && !o_rsp_valid && !o_srq && !o_busy)
    else $error("outputs not idle in reset");
  a_reply_holds: assert property (disable iff (!i_rst_n)
    o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_data))
    else $error("reply changed before accept");
  a_reply_drops: assert property (disable iff (!i_rst_n)
    o_rsp_valid && i_rsp_ready |=> !o_rsp_valid)
    else $error("reply stayed after accept");
  a_reply_byte: assert property (disable iff (!i_rst_n)
    o_rsp_valid |-> o_rsp_data[15:8] == 8'h00)
    else $error("reply upper byte not zero");
  a_opc_latency: assert property (disable iff (!i_rst_n)
    take && i_cmd_code == `CMD_OPC_QUERY && !o_busy && !o_rsp_valid
    |-> ##3 o_rsp_valid && o_rsp_data == 16'h0001)
    else $error("completion reply late or wrong");
  a_busy_follows: assert property (disable iff (!i_rst_n)
    take && !o_busy |=> o_busy)
    else $error("busy not raised after take");
  a_full_busy: assert property (disable iff (!i_rst_n)
    !o_cmd_ready |-> o_busy)
    else $error("refusing while idle");
  a_srq_sticky: assert property (disable iff (!i_rst_n)
    o_srq && !o_busy && !take |=> o_srq)
    else $error("request dropped with no command");
endmodule
bind status_service_request_tree sreq_tree_checker u_sreq_tree_checker (
  .i_sys_clk, .i_rst_n, .i_cmd_valid, .i_cmd_code, .o_cmd_ready,
  .o_rsp_valid, .o_rsp_data, .i_rsp_ready, .o_srq, .o_busy);

// ### remote_ctrl_model.sv
`timescale 1ns/1ps
module remote_ctrl_model (
  input wire i_sys_clk,
  input wire i_slow,
  input wire i_rsp_valid,
  input wire [15:0] i_rsp_data,
  output reg o_rsp_ready,
  output reg [7:0] o_count,
  output reg [15:0] o_data
);
  reg [1:0] ph;
  initial begin
    o_rsp_ready = 1'b0;
    o_count = 8'h00;
    o_data = 16'h0000;
    ph = 2'h0;
  end
  // Reply is taken at the very edge where both sides agree
  always @(posedge i_sys_clk) begin
    if (i_rsp_valid && o_rsp_ready) begin
      o_data <= i_rsp_data;
      o_count <= o_count + 8'h01;
    end
    ph <= ph + 2'h1;
    // Slow mode stalls three cycles in four
    o_rsp_ready <= !i_slow || ph == 2'h3;
  end
endmodule

// ### status_service_request_tree_tb_top.sv
`timescale 1ns/1ps
`include "status_tree_map.vh"
module status_service_request_tree_tb_top;
  reg clk = 0, rst_n = 1, cv = 0, slow = 0, ee = 0, de = 0, qe = 0;
  reg [3:0] cc = 4'h0;
  reg [15:0] cd = 16'h0000;
  reg [5:0] ind = 6'h00, old = 6'h00;
  wire crdy, rv, rr, srq, busy;
  wire [15:0] rd, gd;
  wire [7:0] cnt;
  integer n_fail = 0, n_compared = 0, i, t, t0, s = 57, ptr = 0, ev = 0;
  integer p, v;
  always #10 clk = ~clk;
  status_service_request_tree #(.RESET_CYCLES(64)) u_status_service_request_tree (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(cv), .i_cmd_code(cc),
    .i_cmd_data(cd), .o_cmd_ready(crdy), .o_rsp_valid(rv), .o_rsp_data(rd),
    .i_rsp_ready(rr), .i_indicators(ind), .i_exec_err(ee), .i_dev_err(de),
    .i_query_err(qe), .o_srq(srq), .o_busy(busy));
  remote_ctrl_model u_remote_ctrl_model (.i_sys_clk(clk), .i_slow(slow),
    .i_rsp_valid(rv), .i_rsp_data(rd), .o_rsp_ready(rr), .o_count(cnt),
    .o_data(gd));
  function integer xs;
    begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      xs = s;
    end
  endfunction
  task close_out;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task cmd(input [3:0] c, input [15:0] d);
    reg k;
    begin
      k = 0;
      @(posedge clk);
      #1 cc = c;
      cd = d;
      cv = 1;
      for (t = 0; t < 200 && !k; t = t + 1) begin
        k = crdy;
        @(posedge clk);
        #1;
      end
      cv = 0;
      if (!k) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0t command not taken", $time);
        close_out;
      end
    end
  endtask
  task q(input [3:0] c, input [15:0] d, input [15:0] e);
    reg [7:0] n0;
    begin
      n0 = cnt;
      cmd(c, d);
      for (t = 0; t < 400 && cnt == n0; t = t + 1) @(posedge clk);
      if (cnt == n0) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0t no reply", $time);
        close_out;
      end
      chk(gd, e);
      @(posedge clk);
      #1;
    end
  endtask
  task setchk(input [15:0] es, input [15:0] sr, input e);
    begin
      cmd(`CMD_SET_ESE, es);
      cmd(`CMD_SET_SRE, sr);
      q(`CMD_OPC_QUERY, 0, 16'h0001);
      chk({15'h0, srq}, {15'h0, e});
    end
  endtask
  task setp(input integer pv);
    begin
      cmd(`CMD_SET_CP_PTR, pv[15:0]);
      q(`CMD_OPC_QUERY, 0, 16'h0001);
      ptr = pv & 16'h003B;
    end
  endtask
  task setind(input [5:0] nv);
    begin
      @(posedge clk);
      #1 ind = nv;
      ev = ev | (nv & ~old & ptr & 6'h3B);
      old = nv;
      repeat (3) @(posedge clk);
    end
  endtask
  initial begin
    #1 rst_n = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    q(`CMD_READ_STB, 0, 16'h0000);
    q(`CMD_OPC_QUERY, 0, 16'h0001);
    $display("test reset done");
    @(posedge clk);
    #1 ee = 1;
    de = 1;
    qe = 1;
    @(posedge clk);
    #1 ee = 0;
    de = 0;
    qe = 0;
    cmd(4'hC, 0);
    q(`CMD_READ_ESR, 0, 16'h003C);
    q(`CMD_READ_ESR, 0, 16'h0000);
    @(posedge clk);
    #1 ee = 1;
    @(posedge clk);
    #1 ee = 0;
    setchk(60, 32, 1);
    setchk(60, 0, 0);
    setchk(16, 160, 1);
    setchk(8, 32, 0);
    cmd(`CMD_CLS, 0);
    setchk(60, 32, 0);
    cmd(`CMD_SET_SRE, 0);
    $display("test standard events done");
    setp(0);
    setind(6'h3F);
    q(`CMD_READ_CP_EVENT, 0, 16'h0000);
    setind(6'h00);
    setp(32);
    setind(6'h20);
    setind(6'h00);
    cmd(`CMD_SET_CP_ENAB, 63);
    cmd(`CMD_SET_OPER_ENAB, 512);
    setchk(0, 128, 1);
    q(`CMD_READ_STB, 0, 16'h00C0);
    q(`CMD_READ_CP_EVENT, 0, 16'h0020);
    chk({15'h0, srq}, 16'h0000);
    ev = 0;
    $display("test call summary done");
    for (i = 0; i < 20; i = i + 1) begin
      p = xs() & 63;
      v = xs() & 63;
      setp(p);
      setind(v[5:0]);
      q(`CMD_READ_CP_COND, 0, v & 16'h003B);
      q(`CMD_READ_CP_EVENT, 0, ev[15:0]);
      ev = 0;
    end
    setind(6'h00);
    setp(1);
    setind(6'h01);
    cmd(`CMD_CLS, 0);
    q(`CMD_READ_CP_EVENT, 0, 16'h0000);
    $display("test random transitions done");
    slow = 1;
    cmd(`CMD_RST, 0);
    t0 = $time;
    q(`CMD_OPC_QUERY, 0, 16'h0001);
    t0 = ($time - t0) / 20;
    chk({15'h0, t0 >= 64 && t0 <= 84}, 16'h0001);
    cmd(`CMD_RST, 0);
    cmd(4'hC, 0);
    for (i = 0; i <= 16; i = i + 1) begin
      cmd(`CMD_SET_ESE, (i == 16) ? 16'h0020 : 16'h0000);
    end
    cmd(`CMD_SET_SRE, 32);
    q(`CMD_OPC_QUERY, 0, 16'h0001);
    chk({15'h0, srq}, 16'h0001);
    q(`CMD_READ_STB, 0, 16'h0060);
    $display("test reset and burst done");
    close_out;
  end
endmodule
